// ==== core/acs_pin_watch.sv ====
// pin synchroniser with edge pulses and long-low detection
`timescale 1ns/1ps
module acs_pin_watch #(
   parameter int unsigned LONG_CYCLES = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level,
   output logic fall,
   output logic rise,
   output logic long_low
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   logic [15:0] low_cnt_reg;
   logic [15:0] low_cnt_next;

   // ----------------------------------------------------------------
   // two-stage synchroniser, then an edge history stage
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
         low_cnt_reg <= 16'h0000;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         low_cnt_reg <= low_cnt_next;
      end
   end

   // low-time counter saturates at the threshold
   assign low_cnt_next = sync_reg ? 16'h0000 :
      (low_cnt_reg == 16'(LONG_CYCLES)) ? low_cnt_reg :
      low_cnt_reg + 16'h0001;
   assign level = sync_reg;
   assign fall = last_reg & ~sync_reg;
   assign rise = ~last_reg & sync_reg;
   assign long_low = (low_cnt_reg == 16'(LONG_CYCLES));

endmodule

// ==== core/acs_sequencer.sv ====
// start-up, conversion and global-chop sequencer with AHB-Lite registers
`timescale 1ns/1ps
module acs_sequencer #(
   parameter int unsigned POWERUP_CYCLES = acs_pkg::POWER_ON_SETTLE_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic MASTER_CLOCK_IN,
   input wire logic SYNC_RESET_N,
   input wire logic [23:0] CONV_DATA,
   output logic DATA_READY_N,
   output logic [23:0] RESULT_DATA,
   output logic FILTER_SELECT_FAST,
   output logic FILTER_RESET,
   output logic CHOP_POLARITY,
   output logic [1:0] POWER_MODE,
   output logic DC_TEST_ENABLE,
   output logic PHASE_CAL_ENABLE
);

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   acs_pkg::acs_state_type state_reg;
   acs_pkg::acs_state_type state_next;
   logic long_wait_reg;
   logic long_wait_next;
   logic [31:0] pu_cnt_reg;
   logic [19:0] cnt_reg;
   logic [19:0] cnt_next;
   logic [19:0] cnt_target;
   logic [8:0] ctrl_reg;
   logic [8:0] ctrl_next;
   logic [15:0] ratio_reg;
   logic [15:0] ratio_next;
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] rd_word;
   logic [1:0] fast_cnt_reg;
   logic have_prev_reg;
   logic pol_reg;
   logic [23:0] prev_reg;
   logic [23:0] result_reg;
   logic filt_rst_reg;
   logic data_ready_n_n_reg;
   logic data_ready_n_n_next;
   logic [3:0] data_ready_n_cnt_reg;
   logic sync_level;
   logic sync_fall;
   logic sync_long;
   logic mod_tick;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   acs_pin_watch #(.LONG_CYCLES(acs_pkg::RESET_WIDTH_CYCLES)) u_sync (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pin_in(SYNC_RESET_N),
      .level(sync_level),
      .fall(sync_fall),
      .rise(),
      .long_low(sync_long)
   );

   // each rising edge of the master clock is one modulator period
   acs_pin_watch #(.LONG_CYCLES(1)) u_mclk (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pin_in(MASTER_CLOCK_IN),
      .level(),
      .fall(),
      .rise(mod_tick),
      .long_low()
   );

   // ----------------------------------------------------------------
   // bus slave decode
   // ----------------------------------------------------------------
   wire addr_ok = HSEL && HTRANS[1] && HREADY;
   wire wr_ctrl = wr_pend_reg && (addr_reg == acs_pkg::ADDR_CTRL);
   wire wr_ratio = wr_pend_reg && (addr_reg == acs_pkg::ADDR_RATIO);
   wire wr_cmd = wr_pend_reg && (addr_reg == acs_pkg::ADDR_CMD);
   wire cmd_reset = wr_cmd && HWDATA[acs_pkg::CMD_RESET_BIT];

   // control fields
   wire chop_enable = ctrl_reg[acs_pkg::CTRL_CHOP_BIT];
   wire [3:0] chop_settle_delay = ctrl_reg[acs_pkg::CTRL_SETTLE_LSB +: 4];
   wire [1:0] power_mode_select = ctrl_reg[acs_pkg::CTRL_POWER_LSB +: 2];
   wire chop_next = wr_ctrl ? HWDATA[acs_pkg::CTRL_CHOP_BIT] : chop_enable;

   wire [31:0] status_word = {23'h0, fast_cnt_reg, have_prev_reg,
      data_ready_n_n_reg, pol_reg, long_wait_reg, state_reg};
   assign rd_word =
      (HADDR[7:0] == acs_pkg::ADDR_CTRL) ? {23'h0, ctrl_reg} :
      (HADDR[7:0] == acs_pkg::ADDR_RATIO) ? {16'h0, ratio_reg} :
      (HADDR[7:0] == acs_pkg::ADDR_STATUS) ? status_word : 32'h0;

   // zero wait state, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_reg;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         hrdata_reg <= 32'h0;
      end else begin
         wr_pend_reg <= addr_ok && HWRITE;
         addr_reg <= HADDR[7:0];
         hrdata_reg <= (addr_ok && !HWRITE) ? rd_word : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers, back to defaults on any reset path
   // ----------------------------------------------------------------
   wire cfg_default = cmd_reset || (state_reg == acs_pkg::ST_HOLD);
   assign ctrl_next = cfg_default ? acs_pkg::CTRL_RESET :
      wr_ctrl ? HWDATA[acs_pkg::CTRL_W-1:0] : ctrl_reg;
   assign ratio_next = cfg_default ? acs_pkg::RATIO_RESET :
      wr_ratio ? HWDATA[15:0] : ratio_reg;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_reg <= acs_pkg::CTRL_RESET;
         ratio_reg <= acs_pkg::RATIO_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
         ratio_reg <= ratio_next;
      end
   end

   // ----------------------------------------------------------------
   // events and period counting
   // ----------------------------------------------------------------
   wire running = (state_reg == acs_pkg::ST_CONV) ||
      (state_reg == acs_pkg::ST_CHOP_SETTLE) ||
      (state_reg == acs_pkg::ST_CHOP_CONV);
   wire counting = running || (state_reg == acs_pkg::ST_INIT);
   wire ratio_change = wr_ratio && (HWDATA[15:0] != ratio_reg);
   wire chop_toggle = wr_ctrl && (chop_next != chop_enable);
   wire restart_hit = running &&
      (sync_fall || chop_toggle || (ratio_change && chop_enable));
   wire live = state_reg != acs_pkg::ST_POWERUP;
   wire cmd_hit = cmd_reset && live;
   wire hold_hit = sync_long && live;
   wire quiet = !(restart_hit || cmd_hit || hold_hit);

   // period length of the current phase in modulator periods
   assign cnt_target = (state_reg == acs_pkg::ST_INIT) ?
      (long_wait_reg ? acs_pkg::MOD_WAIT_BASE + acs_pkg::MOD_WAIT_EXTRA :
      acs_pkg::MOD_WAIT_EXTRA) :
      (state_reg == acs_pkg::ST_CONV) ? {4'h0, ratio_reg} :
      (state_reg == acs_pkg::ST_CHOP_SETTLE) ?
      acs_pkg::acs_settle_ticks(chop_settle_delay) :
      acs_pkg::acs_triple(ratio_reg);
   // a period shortened mid-run ends on the next tick instead of wrapping
   wire done = counting && mod_tick && (cnt_reg >= cnt_target - 20'h1);
   wire conv_end = done && (state_reg == acs_pkg::ST_CONV) && quiet;
   wire chop_end = done && (state_reg == acs_pkg::ST_CHOP_CONV) && quiet;
   wire publish = conv_end || (chop_end && have_prev_reg);

   // no modulator clock, no counting
   assign cnt_next = (state_next != state_reg || done || !quiet) ?
      20'h0 : (counting && mod_tick) ? cnt_reg + 20'h1 : cnt_reg;

   // ----------------------------------------------------------------
   // sequence state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      long_wait_next = long_wait_reg;
      unique case (state_reg)
         acs_pkg::ST_POWERUP: begin
            if (pu_cnt_reg == 32'(POWERUP_CYCLES - 1)) begin
               state_next = acs_pkg::ST_INIT;
            end
         end
         acs_pkg::ST_INIT: begin
            if (done) begin
               state_next = chop_enable ? acs_pkg::ST_CHOP_SETTLE :
                  acs_pkg::ST_CONV;
            end
         end
         acs_pkg::ST_CONV: begin
            state_next = acs_pkg::ST_CONV;
         end
         acs_pkg::ST_CHOP_SETTLE: begin
            if (done) begin
               state_next = acs_pkg::ST_CHOP_CONV;
            end
         end
         acs_pkg::ST_CHOP_CONV: begin
            if (done) begin
               state_next = acs_pkg::ST_CHOP_SETTLE;
            end
         end
         acs_pkg::ST_HOLD: begin
            if (sync_level) begin
               state_next = acs_pkg::ST_INIT;
            end
         end
         default: begin
            state_next = acs_pkg::ST_POWERUP;
         end
      endcase
      if (restart_hit) begin
         state_next = chop_next ? acs_pkg::ST_INIT : acs_pkg::ST_CONV;
         long_wait_next = 1'b0;
      end
      if (cmd_hit) begin
         state_next = acs_pkg::ST_INIT;
         long_wait_next = 1'b1;
      end
      if (hold_hit) begin
         state_next = acs_pkg::ST_HOLD;
         long_wait_next = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= acs_pkg::ST_POWERUP;
         long_wait_reg <= 1'b1;
         pu_cnt_reg <= 32'h0;
         cnt_reg <= 20'h0;
      end else begin
         state_reg <= state_next;
         long_wait_reg <= long_wait_next;
         pu_cnt_reg <= pu_cnt_reg + 32'h1;
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // filter choice, polarity and pair averaging
   // ----------------------------------------------------------------
   wire clear_pair = (state_next == acs_pkg::ST_INIT) ||
      (state_next == acs_pkg::ST_HOLD) || (state_next == acs_pkg::ST_CONV);
   wire clear_fast = (state_next == acs_pkg::ST_INIT) && long_wait_next;
   wire [23:0] cur_corr = pol_reg ? 24'h0 - CONV_DATA : CONV_DATA;
   wire [24:0] pair_sum = {prev_reg[23], prev_reg} +
      {cur_corr[23], cur_corr};
   wire [23:0] pair_avg = pair_sum[24:1];
   wire fast_open = fast_cnt_reg != acs_pkg::FAST_SAMPLES;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         fast_cnt_reg <= 2'h0;
         have_prev_reg <= 1'b0;
         pol_reg <= 1'b0;
         prev_reg <= 24'h0;
         result_reg <= 24'h0;
         filt_rst_reg <= 1'b0;
      end else begin
         fast_cnt_reg <= clear_fast ? 2'h0 :
            (conv_end && fast_open) ? fast_cnt_reg + 2'h1 :
            fast_cnt_reg;
         have_prev_reg <= clear_pair ? 1'b0 : chop_end | have_prev_reg;
         pol_reg <= clear_pair ? 1'b0 : pol_reg ^ chop_end;
         prev_reg <= chop_end ? cur_corr : prev_reg;
         result_reg <= conv_end ? CONV_DATA :
            publish ? pair_avg : result_reg;
         filt_rst_reg <= chop_end || restart_hit;
      end
   end

   // ----------------------------------------------------------------
   // ready line: low in power-up and hold, pulsed per sample
   // ----------------------------------------------------------------
   wire ready_low = (state_next == acs_pkg::ST_POWERUP) ||
      (state_next == acs_pkg::ST_HOLD);
   assign data_ready_n_n_next = ready_low ? 1'b0 : publish ? 1'b0 :
      (data_ready_n_cnt_reg > 4'h1) ? 1'b0 : 1'b1;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         data_ready_n_n_reg <= 1'b0;
         data_ready_n_cnt_reg <= 4'h0;
      end else begin
         data_ready_n_n_reg <= data_ready_n_n_next;
         data_ready_n_cnt_reg <= publish ? acs_pkg::READY_PULSE_CYCLES :
            (data_ready_n_cnt_reg != 4'h0) ? data_ready_n_cnt_reg - 4'h1 : 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign DATA_READY_N = data_ready_n_n_reg;
   assign RESULT_DATA = result_reg;
   assign FILTER_SELECT_FAST = fast_open;
   assign FILTER_RESET = filt_rst_reg;
   assign CHOP_POLARITY = pol_reg;
   assign POWER_MODE = acs_pkg::acs_power_decode(power_mode_select);
   assign DC_TEST_ENABLE = ctrl_reg[acs_pkg::CTRL_DC_TEST_BIT] &&
      !chop_enable;
   assign PHASE_CAL_ENABLE = ctrl_reg[acs_pkg::CTRL_PHASE_BIT] &&
      !chop_enable;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_powerup_low: assert property (
      state_reg == acs_pkg::ST_POWERUP |-> !DATA_READY_N)
      else $error("ready line high during power-up");
   a_powerup_rise: assert property (
      ($past(state_reg) == acs_pkg::ST_POWERUP &&
      state_reg == acs_pkg::ST_INIT) |-> DATA_READY_N)
      else $error("ready line did not rise after power-up");
   a_tick_gates_count: assert property (
      (counting && !mod_tick && quiet && state_next == state_reg)
      |=> cnt_reg == $past(cnt_reg))
      else $error("period counter moved without a modulator tick");
   a_startup_wait: assert property (
      (state_reg == acs_pkg::ST_INIT && long_wait_reg && done)
      |-> cnt_reg == 20'h0012b)
      else $error("start-up wait is not 300 periods");
   a_fast_first: assert property (
      (conv_end && fast_cnt_reg < 2'h2) |-> FILTER_SELECT_FAST)
      else $error("early sample not from fast filter");
   a_sinc_later: assert property (
      fast_cnt_reg == 2'h2 |-> !FILTER_SELECT_FAST)
      else $error("fast filter still selected after two samples");
   a_ready_pulse: assert property (
      publish |=> (!DATA_READY_N)[*8])
      else $error("ready pulse shorter than 8 cycles");
   a_chop_swap: assert property (
      chop_end |=> (CHOP_POLARITY != $past(CHOP_POLARITY)) && FILTER_RESET)
      else $error("polarity swap without filter reset");
   a_first_pair: assert property (
      (chop_end && !have_prev_reg) |=> RESULT_DATA == $past(RESULT_DATA))
      else $error("result published after only one conversion");
   a_chop_blocks: assert property (
      chop_enable |-> !DC_TEST_ENABLE && !PHASE_CAL_ENABLE)
      else $error("test or phase path active in chop mode");
   a_power_legal: assert property (
      POWER_MODE != 2'h3)
      else $error("power mode output uses unused code");
   a_hold_entry: assert property (
      hold_hit |=> state_reg == acs_pkg::ST_HOLD && !DATA_READY_N)
      else $error("long sync low did not enter hold");
   a_chop_restart: assert property (
      (restart_hit && chop_next && !cmd_hit && !hold_hit)
      |=> state_reg == acs_pkg::ST_INIT && !long_wait_reg)
      else $error("chop restart did not reload the 44 period wait");

endmodule

// ==== inc/acs_pkg.sv ====
// shared constants, types and helpers of the start-up and chop sequencer
package acs_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_SYS_MHZ = 200;
   localparam int unsigned POWER_ON_SETTLE_TIME_NS = 250000;
   localparam int unsigned POWER_ON_SETTLE_CYCLES =
      (POWER_ON_SETTLE_TIME_NS * CLK_SYS_MHZ) / 1000;
   localparam int unsigned RESET_WIDTH_NS = 10000;
   localparam int unsigned RESET_WIDTH_CYCLES =
      (RESET_WIDTH_NS * CLK_SYS_MHZ + 999) / 1000;
   localparam int unsigned READY_PULSE_NS = 40;
   localparam logic [3:0] READY_PULSE_CYCLES =
      4'((READY_PULSE_NS * CLK_SYS_MHZ + 999) / 1000);

   // modulator-period counts
   localparam logic [19:0] MOD_WAIT_BASE = 20'h00100;
   localparam logic [19:0] MOD_WAIT_EXTRA = 20'h0002c;
   localparam logic [1:0] FAST_SAMPLES = 2'h2;
   localparam logic [15:0] RATIO_RESET = 16'h0400;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RATIO = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam int unsigned CTRL_W = 9;
   localparam int unsigned CTRL_CHOP_BIT = 0;
   localparam int unsigned CTRL_SETTLE_LSB = 1;
   localparam int unsigned CTRL_POWER_LSB = 5;
   localparam int unsigned CTRL_DC_TEST_BIT = 7;
   localparam int unsigned CTRL_PHASE_BIT = 8;
   localparam logic [8:0] CTRL_RESET = 9'h000;
   localparam int unsigned CMD_RESET_BIT = 0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      HIGH_RESOLUTION_MODE = 2'h0,
      LOW_POWER_MODE = 2'h1,
      VERY_LOW_POWER_MODE = 2'h2
   } acs_power_type;

   typedef enum logic [2:0] {
      ST_POWERUP = 3'h0,
      ST_INIT = 3'h1,
      ST_CONV = 3'h3,
      ST_CHOP_CONV = 3'h7,
      ST_CHOP_SETTLE = 3'h5,
      ST_HOLD = 3'h4
   } acs_state_type;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // settle code 0..15 gives 2..65536 modulator periods
   function automatic logic [19:0] acs_settle_ticks(input logic [3:0] code);
      acs_settle_ticks = 20'h1 << ({1'b0, code} + 5'h1);
   endfunction

   // three internal conversions per chopped result
   function automatic logic [19:0] acs_triple(input logic [15:0] ratio);
      acs_triple = {3'h0, ratio, 1'b0} + {4'h0, ratio};
   endfunction

   // unused code falls back to high resolution
   function automatic acs_power_type acs_power_decode(input logic [1:0] sel);
      unique case (sel)
         2'h1: acs_power_decode = LOW_POWER_MODE;
         2'h2: acs_power_decode = VERY_LOW_POWER_MODE;
         default: acs_power_decode = HIGH_RESOLUTION_MODE;
      endcase
   endfunction

endpackage

// ==== verif/acs_host_model.sv ====
// host side: modulator clock source and ready-line watcher
`timescale 1ns/1ps
module acs_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic mark,
   input wire logic data_ready_n,
   output logic master_clock_in,
   output int gap,
   output int falls,
   output int precise
);
   logic [2:0] phase_reg;
   logic ready_d_reg;
   int ticks;
   // ------------------------------------------------------------
   // clock source and sample watcher
   // ------------------------------------------------------------
   // clock stands low until run; each fall latches ticks since last
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 3'h0;
         ready_d_reg <= 1'b0;
         ticks <= 0;
         gap <= 0;
         falls <= 0;
         precise <= 0;
      end else begin
         if (run || phase_reg != 3'h0) begin
            phase_reg <= phase_reg + 3'h1;
         end
         ready_d_reg <= data_ready_n;
         if (ready_d_reg && !data_ready_n) begin
            gap <= ticks;
            ticks <= 0;
            falls <= falls + 1;
            // first two falls carry fast-filter data
            if (falls >= 2) begin
               precise <= precise + 1;
            end
         end else if (mark) begin
            ticks <= 0;
            falls <= 0;
            precise <= 0;
         end else if (phase_reg == 3'h3) begin
            ticks <= ticks + 1;
         end
      end
   end
   assign master_clock_in = phase_reg[2];
endmodule

// ==== verif/adc_startup_and_chop_sequencer_tb.sv ====
// self-checking bench of the start-up and chop sequencer
`timescale 1ns/1ps
module adc_startup_and_chop_sequencer_tb;
   logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic run = 1'b0, mark = 1'b0, sync_reset_n = 1'b1, prev_pol;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0, power_mode;
   logic [2:0] hsize = 3'h2;
   logic [23:0] conv_data = 24'h0, result_data;
   logic hreadyout, hresp, data_ready_n, filter_select_fast, filter_reset;
   logic chop_polarity, dc_test_enable, phase_cal_enable, master_clock_in;
   logic [1:0] pm_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
   int gap, falls, precise, err_count = 0, num_checks = 0, n, i;
   int seed = 32'hde71bc99, pulses = 0, last_pulses = 0, chop_on = 0;
   // clock, design and host
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (filter_reset === 1'b1) pulses++;
   acs_sequencer #(.POWERUP_CYCLES(20)) acs_sequencer_inst (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .MASTER_CLOCK_IN(master_clock_in),
      .SYNC_RESET_N(sync_reset_n), .CONV_DATA(conv_data),
      .DATA_READY_N(data_ready_n), .RESULT_DATA(result_data),
      .FILTER_SELECT_FAST(filter_select_fast), .FILTER_RESET(filter_reset),
      .CHOP_POLARITY(chop_polarity), .POWER_MODE(power_mode),
      .DC_TEST_ENABLE(dc_test_enable), .PHASE_CAL_ENABLE(phase_cal_enable));
   acs_host_model acs_host_model_inst (.clk(clk_sys), .rst_n(rst_n),
      .run(run), .mark(mark), .data_ready_n(data_ready_n),
      .master_clock_in(master_clock_in), .gap(gap), .falls(falls),
      .precise(precise));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic results;
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   // one single word transfer, entered just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
      chk(hresp === 1'b0, "response");
   endtask
   task automatic do_mark;
      mark <= 1'b1;
      @(posedge clk_sys);
      mark <= 1'b0;
   endtask
   // next sample: spacing in ticks, aux = fast flag or chop swap check
   task automatic wait_fall(input int exp, input int tol, input int aux);
      logic f;
      f = filter_select_fast;
      while (data_ready_n !== 1'b1) begin
         @(posedge clk_sys);
         #1;
      end
      while (data_ready_n !== 1'b0) begin
         f = filter_select_fast;
         @(posedge clk_sys);
         #1;
      end
      n = pulses - last_pulses;
      last_pulses = pulses;
      @(posedge clk_sys);
      #1;
      chk(result_data === (chop_on ? 24'h0 : conv_data), "value");
      if (exp >= 0) chk(gap >= exp-tol && gap <= exp+tol, "spacing");
      if (!chop_on && aux >= 0) chk(f === aux[0], "filter");
      if (chop_on && aux == 1)
         chk(n == 1 && chop_polarity !== prev_pol, "swap");
      prev_pol = chop_polarity;
      if (!chop_on) conv_data <= 24'($random(seed));
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk(data_ready_n === 1'b0, "ready in reset");
      n = 0;
      while (data_ready_n !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      chk(n >= 18 && n <= 23, "power-on span");
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk(rd === 32'h400, "ratio default");
      ahb(1'b0, 32'h10, 32'h0, rd);
      chk(rd === 32'h0, "unmapped read");
      run <= 1'b1;
      do_mark();
      wait_fall(1324, 1, 1);
      wait_fall(1024, 0, 1);
      wait_fall(1024, 0, 0);
      chk(precise === 1, "settled count");
      ahb(1'b1, 32'h4, 32'h10, rd);
      wait_fall(-1, 0, -1);
      repeat (2) wait_fall(16, 0, 0);
      ahb(1'b1, 32'h8, 32'h1, rd);
      do_mark();
      wait_fall(1324, 1, 1);
      wait_fall(1024, 0, 1);
      wait_fall(1024, 0, 0);
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk(rd === 32'h400, "ratio after command");
      ahb(1'b1, 32'h4, 32'h10, rd);
      for (i = 0; i < 4; i++) begin
         ahb(1'b1, 32'h0, 32'h180 | (i << 5), rd);
         #1;
         chk(power_mode === pm_exp[i], "power mode");
         chk(dc_test_enable & phase_cal_enable, "test bits");
      end
      chop_on = 1;
      ahb(1'b1, 32'h0, 32'h1a1, rd);
      do_mark();
      #1;
      chk(!dc_test_enable && !phase_cal_enable, "chop blocks");
      wait_fall(44 + 2 * (2 + 48), 1, 2);
      repeat (2) wait_fall(2 + 48, 0, 1);
      ahb(1'b1, 32'h0, 32'h1a7, rd);
      wait_fall(-1, 0, 0);
      wait_fall(16 + 48, 0, 1);
      sync_reset_n <= 1'b0;
      do_mark();
      repeat (10) @(posedge clk_sys);
      sync_reset_n <= 1'b1;
      wait_fall(44 + 2 * (16 + 48), 1, 2);
      sync_reset_n <= 1'b0;
      repeat (2100) @(posedge clk_sys);
      chk(data_ready_n === 1'b0, "held in reset");
      sync_reset_n <= 1'b1;
      @(posedge clk_sys);
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk(rd === 32'h0, "ctrl after pin reset");
      repeat (4) @(posedge clk_sys);
      ahb(1'b0, 32'hc, 32'h0, rd);
      chk(rd === 32'h29, "status after pin reset");
      results();
   end
   // watchdog: the sequence needs about 61k cycles
   initial begin
      #450000;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end
endmodule
